// [pkg/rpdc_pkg.sv]
// Package with register map, field positions, reset values and filter timing
// Contract
// [RQ1] After reset the combined pin acts as a reset input until software picks the interrupt role.
// [RQ2] With the interrupt select bit set, the combined pin is an external interrupt source.
// [RQ3] The external interrupt is taken on a pin edge whose polarity the edge select bit picks.
// [RQ4] Each detected edge sets the interrupt flag; a request is raised only while enabled.
// [RQ5] One bit picks pull-up or pull-down on the pin and another bit switches it on or off.
// [RQ6] In the reset role the pin passes a short-pulse filter, bypassed in the interrupt role.
// [RQ7] The shortest accepted reset pulse is a parameter counted in clock cycles.
// [RQ8] Brownout reset clears the debug pin latch, and a clear latch means general-purpose pins.
// [RQ9] Once set, the latch keeps the shared pins in four-wire debug mode until brownout reset.
// [RQ10] Software writes that try to clear the latch are ignored.
// [RQ11] An unused combined pin has the internal pull-up selected and on, or an external resistor.
package rpdc_pkg;
    localparam int         ADDR_W            = 4;
    localparam int         DATA_W            = 8;
    localparam logic [3:0] ADDR_PIN_CTRL     = 4'h0;
    localparam logic [3:0] ADDR_INT_STATUS   = 4'h1;
    localparam logic [3:0] ADDR_INT_MASK     = 4'h2;
    localparam logic [3:0] ADDR_DEBUG_LOCK   = 4'h3;
    localparam logic [3:0] ADDR_PIN_STATE    = 4'h4;
    // Control register fields
    localparam int         BIT_NMI_SELECT    = 0;
    localparam int         BIT_EDGE_SELECT   = 1;
    localparam int         BIT_PULL_DIR      = 2;
    localparam int         BIT_PULL_EN       = 3;
    localparam int         BIT_NMI_ENABLE    = 4;
    // Status, mask and debug lock fields
    localparam int         BIT_NMI_FLAG      = 0;
    localparam int         BIT_RESET_EVT     = 1;
    localparam int         BIT_LOCK          = 0;
    localparam logic [7:0] CTRL_RESET        = 8'h0C;
    localparam logic [1:0] STATUS_RESET      = 2'h0;
    localparam logic [1:0] MASK_RESET        = 2'h0;
    // Filter length, cycles of the 20 MHz clock
    localparam int         FILTER_CYCLES     = 4;
    localparam int         FILT_W            = 8;
endpackage

// [verilog/rpdc_top.sv]
// Reset/interrupt pin selection, pin filter and write-once debug pin latch
module rpdc_top #(
    parameter int FILTER_CYCLES = rpdc_pkg::FILTER_CYCLES
) (
    input  wire logic       clock_in,
    input  wire logic       rst_n_in,
    input  wire logic       brownout_reset_n_in,
    input  wire logic       clk_en_in,
    input  wire logic [3:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    output logic [7:0]      rdata_out,
    input  wire logic       pin_in,
    output logic            pin_reset_n_out,
    output logic            nmi_req_out,
    output logic            irq_out,
    output logic            pull_up_en_out,
    output logic            pull_down_en_out,
    output logic            debug_pins_jtag_out
);
    logic       rst_s1_reg;
    logic       rst_s2_reg;
    logic       bor_s1_reg;
    logic       bor_s2_reg;
    logic       pin_s1_reg;
    logic       pin_s2_reg;
    logic       pin_prev_reg;
    logic [7:0] ctrl_reg;
    logic [1:0] status_reg;
    logic [1:0] mask_reg;
    logic       debug_pins_lock_select_reg;
    logic [7:0] filt_cnt_reg;
    logic       filt_out_reg;
    logic       nmi_edge;
    logic       reset_evt;
    logic       reset_pin_nmi_select;
    logic       nmi_edge_select;
    logic       ext_nmi_int_enable;

    assign reset_pin_nmi_select = ctrl_reg[rpdc_pkg::BIT_NMI_SELECT];
    assign nmi_edge_select      = ctrl_reg[rpdc_pkg::BIT_EDGE_SELECT];
    assign ext_nmi_int_enable   = ctrl_reg[rpdc_pkg::BIT_NMI_ENABLE];

    // Reset release synchronisers
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end

    always_ff @(posedge clock_in or negedge brownout_reset_n_in) begin
        if (!brownout_reset_n_in) begin
            bor_s1_reg <= 1'b0;
            bor_s2_reg <= 1'b0;
        end else begin
            bor_s1_reg <= 1'b1;
            bor_s2_reg <= bor_s1_reg;
        end
    end

    // Pin synchroniser and previous value for edge detect
    always_ff @(posedge clock_in or negedge rst_s2_reg) begin
        if (!rst_s2_reg) begin
            pin_s1_reg   <= 1'b1;
            pin_s2_reg   <= 1'b1;
            pin_prev_reg <= 1'b1;
        end else if (clk_en_in) begin
            pin_s1_reg   <= pin_in;
            pin_s2_reg   <= pin_s1_reg;
            pin_prev_reg <= pin_s2_reg;
        end
    end

    // Edge of chosen polarity, only in interrupt role, no filter
    assign nmi_edge = reset_pin_nmi_select &&  // see [RQ2] [RQ6]
                      (nmi_edge_select ? (pin_prev_reg && !pin_s2_reg)
                                       : (!pin_prev_reg && pin_s2_reg)); // see [RQ3]

    // Low pulse filter in reset role: low must last FILTER_CYCLES
    always_ff @(posedge clock_in or negedge rst_s2_reg) begin
        if (!rst_s2_reg) begin
            filt_cnt_reg <= 8'h00;
            filt_out_reg <= 1'b1;
        end else if (clk_en_in) begin
            if (reset_pin_nmi_select || pin_s2_reg) begin
                filt_cnt_reg <= 8'h00;  // see [RQ6]
                filt_out_reg <= 1'b1;
            end else if (filt_cnt_reg >= FILTER_CYCLES[7:0] - 8'h01) begin
                filt_out_reg <= 1'b0;  // see [RQ7]
            end else begin
                filt_cnt_reg <= filt_cnt_reg + 8'h01;
            end
        end
    end

    assign reset_evt = clk_en_in && !reset_pin_nmi_select && !pin_s2_reg &&
                       filt_out_reg == 1'b1 && filt_cnt_reg >= FILTER_CYCLES[7:0] - 8'h01;

    // Control register; powers up in reset role
    always_ff @(posedge clock_in or negedge rst_s2_reg) begin
        if (!rst_s2_reg) begin
            ctrl_reg <= rpdc_pkg::CTRL_RESET;  // see [RQ1] [RQ11]
        end else if (clk_en_in && wr_in && addr_in == rpdc_pkg::ADDR_PIN_CTRL) begin
            ctrl_reg <= {3'h0, wdata_in[4:0]};  // see [RQ5]
        end
    end

    // Sticky status, write one to clear, set wins
    always_ff @(posedge clock_in or negedge rst_s2_reg) begin
        if (!rst_s2_reg) begin
            status_reg <= rpdc_pkg::STATUS_RESET;
        end else if (clk_en_in) begin
            status_reg <= (status_reg & ~((wr_in && addr_in == rpdc_pkg::ADDR_INT_STATUS)
                                          ? wdata_in[1:0] : 2'h0))
                          | {reset_evt, nmi_edge};  // see [RQ4]
        end
    end

    always_ff @(posedge clock_in or negedge rst_s2_reg) begin
        if (!rst_s2_reg) begin
            mask_reg <= rpdc_pkg::MASK_RESET;
        end else if (clk_en_in && wr_in && addr_in == rpdc_pkg::ADDR_INT_MASK) begin
            mask_reg <= wdata_in[1:0];
        end
    end

    // Write-once latch, cleared only by brownout
    always_ff @(posedge clock_in or negedge bor_s2_reg) begin
        if (!bor_s2_reg) begin
            debug_pins_lock_select_reg <= 1'b0;  // see [RQ8]
        end else if (clk_en_in && wr_in && addr_in == rpdc_pkg::ADDR_DEBUG_LOCK &&
                     wdata_in[rpdc_pkg::BIT_LOCK]) begin
            debug_pins_lock_select_reg <= 1'b1;  // see [RQ9] [RQ10]
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge clock_in or negedge rst_s2_reg) begin
        if (!rst_s2_reg) begin
            rdata_out <= 8'h00;
        end else if (clk_en_in) begin
            rdata_out <= 8'h00;
            if (rd_in) begin
                unique case (addr_in)
                    rpdc_pkg::ADDR_PIN_CTRL:   rdata_out <= ctrl_reg;
                    rpdc_pkg::ADDR_INT_STATUS: rdata_out <= {6'h00, status_reg};
                    rpdc_pkg::ADDR_INT_MASK:   rdata_out <= {6'h00, mask_reg};
                    rpdc_pkg::ADDR_DEBUG_LOCK: rdata_out <= {7'h00, debug_pins_lock_select_reg};
                    rpdc_pkg::ADDR_PIN_STATE:  rdata_out <= {6'h00, filt_out_reg, pin_s2_reg};
                    default:                   rdata_out <= 8'h00;
                endcase
            end
        end
    end

    // Registered outputs
    always_ff @(posedge clock_in or negedge rst_s2_reg) begin
        if (!rst_s2_reg) begin
            pin_reset_n_out  <= 1'b1;
            nmi_req_out      <= 1'b0;
            irq_out          <= 1'b0;
            pull_up_en_out   <= 1'b1;
            pull_down_en_out <= 1'b0;
        end else if (clk_en_in) begin
            pin_reset_n_out  <= filt_out_reg;  // see [RQ6]
            nmi_req_out      <= status_reg[rpdc_pkg::BIT_NMI_FLAG] && ext_nmi_int_enable; // see [RQ4]
            irq_out          <= |(status_reg & mask_reg);
            pull_up_en_out   <= ctrl_reg[rpdc_pkg::BIT_PULL_EN] && ctrl_reg[rpdc_pkg::BIT_PULL_DIR];
            pull_down_en_out <= ctrl_reg[rpdc_pkg::BIT_PULL_EN] && !ctrl_reg[rpdc_pkg::BIT_PULL_DIR]; // see [RQ5]
        end
    end

    always_ff @(posedge clock_in or negedge bor_s2_reg) begin
        if (!bor_s2_reg) begin
            debug_pins_jtag_out <= 1'b0;
        end else if (clk_en_in) begin
            debug_pins_jtag_out <= debug_pins_lock_select_reg;  // see [RQ9]
        end
    end
endmodule

// [verif/rpdc_monitor.sv]
// Checker for pin role, filter, pull and debug latch behaviour
module rpdc_monitor #(
    parameter int FILTER_CYCLES = 4
) (
    input wire logic       clock_in,
    input wire logic       rst_n_in,
    input wire logic       brownout_reset_n_in,
    input wire logic [3:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic       wr_in,
    input wire logic       rd_in,
    input wire logic [7:0] rdata_out,
    input wire logic       pin_in,
    input wire logic       pin_reset_n_out,
    input wire logic       nmi_req_out,
    input wire logic       pull_up_en_out,
    input wire logic       pull_down_en_out,
    input wire logic       debug_pins_jtag_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    // Consecutive raw low samples of the pin, saturating
    logic [7:0] low_cnt;
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) low_cnt <= 8'h00;
        else if (pin_in) low_cnt <= 8'h00;
        else if (low_cnt != 8'hFF) low_cnt <= low_cnt + 8'h01;
    end
    a_pull_exclusive: assert property (!(pull_up_en_out && pull_down_en_out))
        else $error("pull-up and pull-down both on");
    a_filter_min_len: assert property ($fell(pin_reset_n_out) |-> low_cnt >= FILTER_CYCLES)
        else $error("reset request after a short pulse");
    a_filter_release: assert property (pin_in [*5] |-> pin_reset_n_out)
        else $error("reset request held with pin high");
    a_lock_holds: assert property (debug_pins_jtag_out && brownout_reset_n_in ##1
        brownout_reset_n_in |-> debug_pins_jtag_out)
        else $error("debug mode left without brownout");
    a_lock_sets: assert property (wr_in && addr_in == rpdc_pkg::ADDR_DEBUG_LOCK && wdata_in[0]
        ##1 brownout_reset_n_in |-> ##[0:2] debug_pins_jtag_out)
        else $error("debug mode not entered");
    a_brownout_clears: assert property (!brownout_reset_n_in |-> ##[0:1] !debug_pins_jtag_out)
        else $error("debug mode kept over brownout");
    a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
        else $error("read data outside its cycle");
    a_nmi_no_reset: assert property ($rose(nmi_req_out) |-> pin_reset_n_out)
        else $error("pin acts as reset in interrupt role");
endmodule
bind rpdc_top rpdc_monitor #(.FILTER_CYCLES(FILTER_CYCLES)) u_mon (.clock_in(clock_in),
    .rst_n_in(rst_n_in), .brownout_reset_n_in(brownout_reset_n_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .pin_in(pin_in),
    .pin_reset_n_out(pin_reset_n_out), .nmi_req_out(nmi_req_out),
    .pull_up_en_out(pull_up_en_out), .pull_down_en_out(pull_down_en_out),
    .debug_pins_jtag_out(debug_pins_jtag_out));

// [verif/rpdc_pin_source.sv]
// Model of the external source on the combined reset/interrupt pin
module rpdc_pin_source (
    input  wire logic drive_en_in,
    input  wire logic drive_val_in,
    input  wire logic pull_up_in,
    input  wire logic pull_down_in,
    output logic      pin_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic last_reg = 1'b1;
    // Driven level wins, else the selected pull, else a floating level
    always @* begin
        if (drive_en_in) pin_out = drive_val_in;
        else if (pull_up_in) pin_out = 1'b1;
        else if (pull_down_in) pin_out = 1'b0;
        else pin_out = ~last_reg;
    end
    // Remember the last driven level
    always @(drive_en_in or drive_val_in) if (drive_en_in) last_reg = drive_val_in;
endmodule

// [verif/testbench.sv]
// Testbench for pin role selection, filter, pulls and debug latch
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int FLT = 3;
    localparam logic [3:0] A_CTL = rpdc_pkg::ADDR_PIN_CTRL;
    localparam logic [3:0] A_STS = rpdc_pkg::ADDR_INT_STATUS;
    localparam logic [3:0] A_LCK = rpdc_pkg::ADDR_DEBUG_LOCK;
    logic clk = 1'b0, rst_n = 1'b0, bor_n = 1'b0, wr = 1'b0, rd = 1'b0;
    logic drv_en = 1'b0, drv_val = 1'b1, pin, pin_rst_n, nmi, irq, pu, pd, jtag;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, rdata;
    int fails = 0, total_checks = 0, c;
    always #25 clk = ~clk;
    rpdc_top #(.FILTER_CYCLES(FLT)) dut (.clock_in(clk), .rst_n_in(rst_n),
        .brownout_reset_n_in(bor_n), .clk_en_in(1'b1), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .pin_in(pin), .pin_reset_n_out(pin_rst_n),
        .nmi_req_out(nmi), .irq_out(irq), .pull_up_en_out(pu), .pull_down_en_out(pd),
        .debug_pins_jtag_out(jtag));
    rpdc_pin_source u_pin (.drive_en_in(drv_en), .drive_val_in(drv_val), .pull_up_in(pu),
        .pull_down_in(pd), .pin_out(pin));
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // One register cycle, write or read; read data is settled on return
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        tick(1);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic wait_sig(ref logic s, input logic v, output int n);
        n = 0;
        while (s !== v && n < 20) begin
            tick(1);
            n++;
        end
        chk("wait", 8'(v), 8'(s));
        if (s !== v) complete_run();
    endtask
    initial begin
        tick(6);
        rst_n <= 1'b1;
        bor_n <= 1'b1;
        tick(3);
        bus(0, A_CTL, 8'h00);
        chk("ctrl reset", 8'h0C, rdata);
        chk("pull reset", 8'h02, 8'({pu, pd}));
        @(posedge clk) drv_en <= 1'b1;
        drv_val <= 1'b0;
        tick(FLT - 1);
        drv_val <= 1'b1;
        repeat (8) begin
            tick(1);
            chk("short pulse", 8'h01, 8'(pin_rst_n));
        end
        @(posedge clk) drv_val <= 1'b0;
        wait_sig(pin_rst_n, 1'b0, c);
        chk("filter length", 8'h01, 8'(c > FLT));
        @(posedge clk) drv_val <= 1'b1;
        wait_sig(pin_rst_n, 1'b1, c);
        bus(1, A_STS, 8'h03);
        bus(1, A_CTL, 8'h1F);
        @(posedge clk) drv_val <= 1'b0;
        wait_sig(nmi, 1'b1, c);
        tick(FLT + 4);
        chk("bypass", 8'h01, 8'(pin_rst_n));
        bus(0, A_STS, 8'h00);
        chk("flag", 8'h01, rdata);
        chk("irq masked", 8'h00, 8'(irq));
        bus(1, rpdc_pkg::ADDR_INT_MASK, 8'h01);
        tick(2);
        chk("irq", 8'h01, 8'(irq));
        bus(1, A_STS, 8'h01);
        tick(2);
        chk("cleared", 8'h00, 8'({nmi, irq}));
        @(posedge clk) drv_val <= 1'b1;
        tick(8);
        bus(0, A_STS, 8'h00);
        chk("wrong edge", 8'h00, rdata);
        bus(1, A_CTL, 8'h1D);
        @(posedge clk) drv_val <= 1'b0;
        tick(8);
        chk("wrong edge", 8'h00, 8'(nmi));
        @(posedge clk) drv_val <= 1'b1;
        wait_sig(nmi, 1'b1, c);
        bus(1, A_CTL, 8'h0D);
        tick(2);
        chk("disabled", 8'h00, 8'(nmi));
        for (int i = 0; i < 4; i++) begin
            bus(1, A_CTL, 8'(i << 2));
            tick(2);
            chk("pull", 8'({i[1] & i[0], i[1] & !i[0]}), 8'({pu, pd}));
        end
        chk("gpio", 8'h00, 8'(jtag));
        bus(1, A_LCK, 8'h01);
        tick(2);
        chk("lock set", 8'h01, 8'(jtag));
        bus(1, A_LCK, 8'h00);
        tick(2);
        chk("lock clear", 8'h01, 8'(jtag));
        @(posedge clk) rst_n <= 1'b0;
        tick(2);
        rst_n <= 1'b1;
        tick(3);
        chk("lock reset", 8'h01, 8'(jtag));
        bus(0, 4'hF, 8'h00);
        chk("unmapped", 8'h00, rdata);
        @(posedge clk) bor_n <= 1'b0;
        tick(2);
        bor_n <= 1'b1;
        tick(3);
        chk("brownout", 8'h00, 8'(jtag));
        complete_run();
    end
endmodule
